// ==== rtl/fcesr_regs.svh ====
// Opcodes, register offsets, reset values and timing counts.
// Assumes inclusion by bare name from the package and both ends.
`ifndef FCESR_REGS_SVH
`define FCESR_REGS_SVH

// ============================================================
// Link opcodes
`define FCESR_OP_WREN      8'h06
`define FCESR_OP_WRDI      8'h04
`define FCESR_OP_ERASE_A   8'h60
`define FCESR_OP_ERASE_B   8'hc7
`define FCESR_OP_SUSPEND   8'h75
`define FCESR_OP_RESUME    8'h7a
`define FCESR_OP_RDSTAT    8'h05
`define FCESR_OP_WRSTAT    8'h01
`define FCESR_OP_READ      8'h03
`define FCESR_OP_PROG      8'h02
`define FCESR_OP_BLK4      8'h20
`define FCESR_OP_BLK32     8'h52
`define FCESR_OP_BLK64     8'hd8

// ============================================================
// Ignored address bits of each block erase size
`define FCESR_MASK_4K      24'h000fff
`define FCESR_MASK_32K     24'h007fff
`define FCESR_MASK_64K     24'h00ffff

// ============================================================
// Status byte fields of the device
`define FCESR_ST_BUSY      0
`define FCESR_ST_WEN       1
`define FCESR_ST_ESUS      2
`define FCESR_ST_PSUS      3

// ============================================================
// Controller register offsets and fields
`define FCESR_REG_OPCODE   8'h00
`define FCESR_REG_TXWORD   8'h04
`define FCESR_REG_CTRL     8'h08
`define FCESR_REG_STATUS   8'h0c
`define FCESR_CTRL_START   8
`define FCESR_RST_WORD     32'h0000_0000

// ============================================================
// Timing
`define FCESR_CLK_PERIOD_NS   4
`define FCESR_SCLK_PERIOD_NS  160
`define FCESR_SCLK_HALF_CYC \
    (`FCESR_SCLK_PERIOD_NS / (2 * `FCESR_CLK_PERIOD_NS))

`endif

// ==== rtl/fcesr_pkg.sv ====
// Types shared by the controller and the flash end.
// Assumes the constants header sits in the include path.
`include "fcesr_regs.svh"

package fcesr_pkg;

    // ============================================================
    // Controller sequencer states
    typedef enum logic [2:0] {
        FCESR_IDLE  = 3'b000,
        FCESR_SETUP = 3'b001,
        FCESR_HIGH  = 3'b010,
        FCESR_LOW   = 3'b011,
        FCESR_HOLD  = 3'b100,
        FCESR_GAP   = 3'b101
    } fcesr_state_type;

    typedef logic [7:0]  fcesr_byte_type;
    typedef logic [23:0] fcesr_addr_type;

endpackage

// ==== rtl/fcesr_spi_if.sv ====
// Serial link between the controller and the flash end.
// Assumes both ends share one system clock; the link is asynchronous.
`timescale 1ns/10ps

interface fcesr_spi_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;

    modport host (
        output sclk,
        output cs_n,
        output mosi,
        input  miso
    );

    modport flash (
        input  sclk,
        input  cs_n,
        input  mosi,
        output miso
    );
endinterface

// ==== rtl/fcesr_flash.sv ====
// Flash end: command decode, write enable latch, suspend and resume.
// Assumes a mode 0 link sampled by hclk, far slower than hclk.
`timescale 1ns/10ps
`include "fcesr_regs.svh"
module fcesr_flash #(
    parameter int unsigned CNT_W        = 32,
    parameter int unsigned CHIP_CYC     = 200000,
    parameter int unsigned BLOCK_CYC    = 20000,
    parameter int unsigned PROG_CYC     = 5000,
    parameter int unsigned RESUME_CYC   = 64,
    parameter logic [7:0]  UNDEF_BYTE   = 8'h5a
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    fcesr_spi_if.flash                spi,
    input  wire logic                 array_protected,
    output logic                      write_enable_latch,
    output logic                      erase_suspended_flag,
    output logic                      program_suspended_flag,
    output logic                      ready_busy_indication,
    output logic                      read_undefined
);
    import fcesr_pkg::*;
    // ============================================================
    // Pin synchronisers and edge detection
    logic [2:0]     sclk_sync_ff;
    logic [2:0]     cs_sync_ff;
    logic [1:0]     mosi_sync_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_sync_ff <= 3'h0;
            cs_sync_ff   <= 3'h7;
            mosi_sync_ff <= 2'h0;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[1:0], spi.sclk};
            cs_sync_ff   <= {cs_sync_ff[1:0], spi.cs_n};
            mosi_sync_ff <= {mosi_sync_ff[0], spi.mosi};
        end
    end
    wire selected    = ~cs_sync_ff[1];
    wire frame_start = cs_sync_ff[2] & ~cs_sync_ff[1];
    wire frame_end   = ~cs_sync_ff[2] & cs_sync_ff[1];
    wire sclk_rise   = selected & sclk_sync_ff[1] & ~sclk_sync_ff[2];
    wire sclk_fall   = selected & ~sclk_sync_ff[1] & sclk_sync_ff[2];

    // ============================================================
    // Frame receiver
    logic [2:0]     bit_cnt_ff;
    logic [2:0]     byte_cnt_ff;
    fcesr_byte_type shift_ff;
    fcesr_byte_type opcode_ff;
    fcesr_addr_type addr_ff;
    logic           miso_ff;
    wire fcesr_byte_type rx_byte = {shift_ff[6:0], mosi_sync_ff[1]};
    wire byte_done  = sclk_rise & (bit_cnt_ff == 3'h7);
    wire is_read    = opcode_ff == `FCESR_OP_READ;
    wire in_data    = byte_cnt_ff >= 3'h4;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt_ff  <= 3'h0;
            byte_cnt_ff <= 3'h0;
            shift_ff    <= 8'h00;
            opcode_ff   <= 8'h00;
            addr_ff     <= 24'h000000;
        end else if (frame_start) begin
            bit_cnt_ff  <= 3'h0;
            byte_cnt_ff <= 3'h0;
            opcode_ff   <= 8'h00;
        end else if (sclk_rise) begin
            shift_ff   <= rx_byte;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (byte_done && byte_cnt_ff != 3'h7)
                byte_cnt_ff <= byte_cnt_ff + 3'h1;
            if (byte_done && byte_cnt_ff == 3'h0)
                opcode_ff <= rx_byte;
            if (byte_done && byte_cnt_ff != 3'h0 && !in_data)
                addr_ff <= {addr_ff[15:0], rx_byte};
            if (byte_done && in_data && is_read)
                addr_ff <= addr_ff + 24'h000001;
        end
    end

    // ============================================================
    // Operation state
    logic                 wen_ff;
    logic                 esus_ff;
    logic                 psus_ff;
    logic                 erase_act_ff;
    logic                 chip_ff;
    logic                 prog_act_ff;
    fcesr_addr_type       eaddr_ff;
    fcesr_addr_type       emask_ff;
    fcesr_addr_type       paddr_ff;
    logic [CNT_W-1:0]     erase_left_ff;
    logic [CNT_W-1:0]     prog_left_ff;
    logic [CNT_W-1:0]     startup_ff;
    wire starting  = startup_ff != '0;
    wire erase_run = erase_act_ff & ~esus_ff;
    wire prog_run  = prog_act_ff & ~psus_ff;
    wire busy      = erase_run | prog_run | starting;
    wire suspended = esus_ff | psus_ff;
    // Matches against the area that the suspended operation owns.
    wire fcesr_addr_type nxt_mask =
        opcode_ff == `FCESR_OP_BLK4  ? `FCESR_MASK_4K  :
        opcode_ff == `FCESR_OP_BLK32 ? `FCESR_MASK_32K : `FCESR_MASK_64K;
    wire addr_in_eblock = esus_ff &
        ((addr_ff & ~emask_ff) == (eaddr_ff & ~emask_ff));
    wire page_in_new_blk = psus_ff &
        ((paddr_ff & ~nxt_mask) == (addr_ff & ~nxt_mask));
    wire addr_in_page = psus_ff & (addr_ff[23:8] == paddr_ff[23:8]);

    // ============================================================
    // Command decode at deselect
    wire aligned    = bit_cnt_ff == 3'h0;
    wire have_op    = byte_cnt_ff != 3'h0;
    wire good_end   = frame_end & aligned & have_op;
    wire bad_end    = frame_end & ~aligned & have_op;
    wire op_chip    = opcode_ff == `FCESR_OP_ERASE_A ||
                      opcode_ff == `FCESR_OP_ERASE_B;
    wire op_blk     = opcode_ff == `FCESR_OP_BLK4 ||
                      opcode_ff == `FCESR_OP_BLK32 ||
                      opcode_ff == `FCESR_OP_BLK64;
    wire op_prog    = opcode_ff == `FCESR_OP_PROG;
    wire op_wrstat  = opcode_ff == `FCESR_OP_WRSTAT;
    wire wr_cmd     = op_chip | op_blk | op_prog | op_wrstat;
    wire wr_ready   = ~busy & wen_ff;
    wire chip_ok    = good_end & op_chip & wr_ready & ~suspended;
    wire chip_rej   = chip_ok & array_protected;
    wire blk_try    = good_end & op_blk & wr_ready & ~esus_ff;
    wire blk_full   = byte_cnt_ff >= 3'h4;
    wire blk_rej    = blk_try & (~blk_full | array_protected |
                      page_in_new_blk);
    wire prog_try   = good_end & op_prog & wr_ready & ~psus_ff;
    wire prog_full  = byte_cnt_ff >= 3'h5;
    wire prog_rej   = prog_try & (~prog_full | array_protected |
                      addr_in_eblock);
    wire wrstat_ok  = good_end & op_wrstat & wr_ready & ~suspended;
    wire odd_rej    = bad_end & wr_cmd & ~busy &
                      ~(op_wrstat & suspended);
    wire chip_go    = chip_ok & ~array_protected;
    wire blk_go     = blk_try & ~blk_rej;
    wire prog_go    = prog_try & ~prog_rej;
    wire suspend_go = good_end & (opcode_ff == `FCESR_OP_SUSPEND) &
                      (erase_run | prog_run) & ~starting &
                      ~(erase_run & chip_ff) &
                      ~(prog_run & esus_ff);
    wire resume_go  = good_end & (opcode_ff == `FCESR_OP_RESUME) &
                      suspended & ~busy;
    wire wen_set    = good_end & ~busy & (opcode_ff == `FCESR_OP_WREN);
    wire wen_clr    = (good_end & ~busy &
                      (opcode_ff == `FCESR_OP_WRDI)) |
                      chip_rej | odd_rej | blk_rej | prog_rej |
                      chip_go | blk_go | prog_go | wrstat_ok;

    // ============================================================
    // Latches and flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wen_ff  <= 1'b0;
            esus_ff <= 1'b0;
            psus_ff <= 1'b0;
        end else begin
            if (wen_clr)
                wen_ff <= 1'b0;
            else if (wen_set)
                wen_ff <= 1'b1;
            if (suspend_go && erase_run)
                esus_ff <= 1'b1;
            else if (resume_go && !psus_ff)
                esus_ff <= 1'b0;
            if (suspend_go && prog_run)
                psus_ff <= 1'b1;
            else if (resume_go)
                psus_ff <= 1'b0;
        end
    end

    // ============================================================
    // Self-timed engines
    // A suspended engine keeps its remaining count, so a resume
    // picks up exactly where the halt left it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            erase_act_ff  <= 1'b0;
            chip_ff       <= 1'b0;
            eaddr_ff      <= 24'h000000;
            emask_ff      <= 24'h000000;
            erase_left_ff <= '0;
        end else if (chip_go) begin
            erase_act_ff  <= 1'b1;
            chip_ff       <= 1'b1;
            emask_ff      <= 24'hffffff;
            erase_left_ff <= CNT_W'(CHIP_CYC);
        end else if (blk_go) begin
            erase_act_ff  <= 1'b1;
            chip_ff       <= 1'b0;
            eaddr_ff      <= addr_ff;
            emask_ff      <= nxt_mask;
            erase_left_ff <= CNT_W'(BLOCK_CYC);
        end else if (erase_run && !starting && !suspend_go) begin
            erase_left_ff <= erase_left_ff - CNT_W'(1);
            if (erase_left_ff <= CNT_W'(1))
                erase_act_ff <= 1'b0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prog_act_ff  <= 1'b0;
            paddr_ff     <= 24'h000000;
            prog_left_ff <= '0;
        end else if (prog_go) begin
            prog_act_ff  <= 1'b1;
            paddr_ff     <= addr_ff;
            prog_left_ff <= CNT_W'(PROG_CYC);
        end else if (prog_run && !starting && !suspend_go) begin
            prog_left_ff <= prog_left_ff - CNT_W'(1);
            if (prog_left_ff <= CNT_W'(1))
                prog_act_ff <= 1'b0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            startup_ff <= '0;
        else if (resume_go)
            startup_ff <= CNT_W'(RESUME_CYC);
        else if (starting)
            startup_ff <= startup_ff - CNT_W'(1);
    end

    // ============================================================
    // Read data
    wire rd_undef = is_read & in_data &
                    (addr_in_eblock | addr_in_page);
    wire fcesr_byte_type status_byte = {4'h0, psus_ff, esus_ff,
                                        wen_ff, busy};
    wire fcesr_byte_type out_byte =
        opcode_ff == `FCESR_OP_RDSTAT ? status_byte :
        rd_undef ? UNDEF_BYTE : 8'hff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            miso_ff <= 1'b0;
        else if (sclk_fall)
            miso_ff <= out_byte[~bit_cnt_ff];
    end
    assign spi.miso               = miso_ff;
    assign write_enable_latch     = wen_ff;
    assign erase_suspended_flag   = esus_ff;
    assign program_suspended_flag = psus_ff;
    assign ready_busy_indication  = busy;
    assign read_undefined         = rd_undef & selected;
endmodule

// ==== rtl/fcesr_host.sv ====
// Controller end: AHB-Lite slave registers that send one framed command.
// Assumes a single AHB-Lite master and one flash end on the link.
`timescale 1ns/10ps
`include "fcesr_regs.svh"

module fcesr_host #(
    parameter int unsigned HALF_CYC = `FCESR_SCLK_HALF_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    fcesr_spi_if.host        spi
);
    import fcesr_pkg::*;

    // ============================================================
    // Bus slave
    logic              wr_pend_ff;
    logic [7:0]        wr_addr_ff;
    logic [31:0]       hrdata_ff;
    fcesr_byte_type    opcode_ff;
    logic [31:0]       txword_ff;
    logic [2:0]        len_ff;
    fcesr_byte_type    rx_ff;
    fcesr_state_type   state_ff;

    wire addr_ok  = hsel & hready & htrans[1];
    wire frame_on = state_ff != FCESR_IDLE;
    wire start    = wr_pend_ff & (wr_addr_ff == `FCESR_REG_CTRL) &
                    hwdata[`FCESR_CTRL_START] & ~frame_on;
    wire [31:0] rd_word =
        haddr == `FCESR_REG_OPCODE ? {24'h0, opcode_ff} :
        haddr == `FCESR_REG_TXWORD ? txword_ff :
        haddr == `FCESR_REG_CTRL   ? {29'h0, len_ff} :
        haddr == `FCESR_REG_STATUS ? {16'h0, rx_ff, 7'h0, frame_on} :
        32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata_ff  <= `FCESR_RST_WORD;
        end else begin
            wr_pend_ff <= addr_ok & hwrite;
            wr_addr_ff <= haddr;
            if (addr_ok && !hwrite)
                hrdata_ff <= rd_word;
        end
    end

    // Writes to the frame registers while a frame runs are dropped,
    // so the bits on the wire never change mid-frame.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opcode_ff <= 8'h00;
            txword_ff <= `FCESR_RST_WORD;
            len_ff    <= 3'h0;
        end else if (wr_pend_ff && !frame_on) begin
            if (wr_addr_ff == `FCESR_REG_OPCODE)
                opcode_ff <= hwdata[7:0];
            if (wr_addr_ff == `FCESR_REG_TXWORD)
                txword_ff <= hwdata;
            if (wr_addr_ff == `FCESR_REG_CTRL)
                len_ff <= hwdata[2] ? 3'h4 : hwdata[2:0];
        end
    end

    // ============================================================
    // Link sequencer, mode 0, clock made by dividing hclk
    logic [15:0]  div_ff;
    logic [5:0]   bit_ff;
    logic [39:0]  tx_ff;
    logic         sclk_ff;
    logic         cs_n_ff;
    logic [1:0]   miso_sync_ff;

    wire        tick     = div_ff == 16'(HALF_CYC - 1);
    wire [5:0]  last_bit = {len_ff, 3'h7};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            miso_sync_ff <= 2'h0;
        else
            miso_sync_ff <= {miso_sync_ff[0], spi.miso};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            div_ff <= 16'h0000;
        else if (start || tick)
            div_ff <= 16'h0000;
        else if (frame_on)
            div_ff <= div_ff + 16'h0001;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= FCESR_IDLE;
            sclk_ff  <= 1'b0;
            cs_n_ff  <= 1'b1;
            bit_ff   <= 6'h00;
            tx_ff    <= 40'h0;
            rx_ff    <= 8'h00;
        end else if (start) begin
            state_ff <= FCESR_SETUP;
            cs_n_ff  <= 1'b0;
            bit_ff   <= 6'h00;
            tx_ff    <= {opcode_ff, txword_ff};
        end else if (tick) begin
            unique case (state_ff)
                FCESR_SETUP, FCESR_LOW: begin
                    state_ff <= FCESR_HIGH;
                    sclk_ff  <= 1'b1;
                    rx_ff    <= {rx_ff[6:0], miso_sync_ff[1]};
                end
                FCESR_HIGH: begin
                    sclk_ff  <= 1'b0;
                    tx_ff    <= {tx_ff[38:0], 1'b0};
                    bit_ff   <= bit_ff + 6'h01;
                    state_ff <= (bit_ff == last_bit) ? FCESR_HOLD
                                                     : FCESR_LOW;
                end
                FCESR_HOLD: begin
                    cs_n_ff  <= 1'b1;
                    state_ff <= FCESR_GAP;
                end
                FCESR_GAP:  state_ff <= FCESR_IDLE;
                FCESR_IDLE: state_ff <= FCESR_IDLE;
                default:    state_ff <= FCESR_IDLE;
            endcase
        end
    end

    assign spi.sclk  = sclk_ff;
    assign spi.cs_n  = cs_n_ff;
    assign spi.mosi  = tx_ff[39];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;

endmodule

// ==== dv/fcesr_asserts.sv ====
// Checker for the serial link and the flag outputs of the flash end.
// Assumes instantiation beside the link, all inputs on the same hclk.
`timescale 1ns/10ps

module fcesr_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic write_enable_latch,
    input wire logic erase_suspended_flag,
    input wire logic program_suspended_flag,
    input wire logic ready_busy_indication
);
    // ============================================================
    // Properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // The flash end needs a few cycles of deselect to see a frame end.
    sequence s_gap;
        cs_n [*3];
    endsequence

    a_sclk_idle: assert property (cs_n |-> !sclk)
        else $error("link clock moved while deselected");
    a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("host data changed while link clock high");
    a_cs_gap: assert property ($rose(cs_n) |-> s_gap)
        else $error("deselect gap too short");
    a_latch_on_cs: assert property (
        $changed(write_enable_latch) |-> $past(cs_n, 3))
        else $error("latch changed inside a frame");
    a_suspend_ready: assert property (
        $rose(erase_suspended_flag) || $rose(program_suspended_flag)
        |-> !ready_busy_indication && $past(cs_n, 3))
        else $error("suspend did not report ready");
    a_resume_busy: assert property (
        $fell(erase_suspended_flag) || $fell(program_suspended_flag)
        |-> ready_busy_indication)
        else $error("resume did not report busy");
    a_program_first: assert property (
        $fell(erase_suspended_flag) |-> !program_suspended_flag)
        else $error("erase resumed ahead of program");
    a_start_clears: assert property (
        $rose(ready_busy_indication) && !$fell(erase_suspended_flag)
        && !$fell(program_suspended_flag) |-> !write_enable_latch)
        else $error("operation started with latch still set");
endmodule

// ==== dv/flash_chip_erase_suspend_resume_tb.sv ====
// Testbench: AHB-Lite master drives the controller, flash end listens.
// Assumes the constants header is in the include path.
`timescale 1ns/10ps
`include "fcesr_regs.svh"

module flash_chip_erase_suspend_resume_tb;
    import fcesr_pkg::*;
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic [7:0]  haddr   = 8'h00;
    logic [1:0]  htrans  = 2'b00;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic        prot    = 1'b0;
    logic [31:0] rd;
    wire         hready;
    wire [31:0]  hrdata;
    wire         wen, esus, psus, busy, resp;
    int          miscompares     = 0;
    int          samples_checked = 0;

    fcesr_spi_if spi_link ();
    fcesr_host i_fcesr_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(resp),
        .hrdata(hrdata), .spi(spi_link));
    // Short counts; resume start-up outlasts one command frame.
    fcesr_flash #(.CHIP_CYC(3000), .BLOCK_CYC(3000), .PROG_CYC(1500),
        .RESUME_CYC(600)) i_fcesr_flash (.hclk(hclk), .hresetn(hresetn),
        .spi(spi_link), .array_protected(prot), .write_enable_latch(wen),
        .erase_suspended_flag(esus), .program_suspended_flag(psus),
        .ready_busy_indication(busy), .read_undefined());
    fcesr_asserts i_fcesr_asserts (.hclk(hclk), .hresetn(hresetn),
        .sclk(spi_link.sclk), .cs_n(spi_link.cs_n), .mosi(spi_link.mosi),
        .miso(spi_link.miso), .write_enable_latch(wen),
        .erase_suspended_flag(esus), .program_suspended_flag(psus),
        .ready_busy_indication(busy));

    always #2 hclk = ~hclk;

    // ============================================================
    // Tasks
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h seen %h", nm, exp, got);
        end
    endtask

    // Sends one frame, waits for it to end and for the flash to act.
    task automatic cmd(input logic [7:0] op, input logic [31:0] w,
                       input logic [2:0] n);
        int k;
        ahb(1'b1, `FCESR_REG_OPCODE, {24'h0, op}, rd);
        ahb(1'b1, `FCESR_REG_TXWORD, w, rd);
        ahb(1'b1, `FCESR_REG_CTRL, {23'h0, 1'b1, 5'h0, n}, rd);
        k = 0;
        do begin
            ahb(1'b0, `FCESR_REG_STATUS, 32'h0, rd);
            k++;
        end while (rd[0] !== 1'b0 && k < 2000);
        if (k >= 2000) chk("frame_end", rd[0], 32'h0);
        repeat (8) @(posedge hclk);
    endtask

    task automatic last_byte(input logic [7:0] op, input logic [31:0] w,
                             input logic [2:0] n);
        cmd(op, w, n);
        ahb(1'b0, `FCESR_REG_STATUS, 32'h0, rd);
    endtask

    task automatic idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 20000) begin
            @(posedge hclk);
            k++;
        end
        chk("idle", busy, 32'h0);
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ============================================================
    // Tests
    initial begin
        #300000;
        miscompares++;
        $display("[ERR] watchdog exp done seen hang");
        end_sim();
    end

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, `FCESR_REG_STATUS, 32'h0, rd);
        chk("status_rst", rd, `FCESR_RST_WORD);
        ahb(1'b0, 8'h10, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        chk("hresp_okay", resp, 32'h0);
        cmd(`FCESR_OP_ERASE_A, 32'h0, 3'd0);
        chk("erase_no_latch", busy, 32'h0);
        $display("test no_latch done");
        for (int i = 0; i < 2; i++) begin
            cmd(`FCESR_OP_WREN, 32'h0, 3'd0);
            chk("latch_set", wen, 32'h1);
            cmd(i ? `FCESR_OP_ERASE_B : `FCESR_OP_ERASE_A, 32'ha5a50000, 3'd2);
            chk("chip_busy", busy, 32'h1);
            chk("chip_latch", wen, 32'h0);
            cmd(`FCESR_OP_SUSPEND, 32'h0, 3'd0);
            chk("chip_nosus", esus, 32'h0);
            last_byte(`FCESR_OP_RDSTAT, 32'h0, 3'd1);
            chk("chip_stat", rd[15:8], 32'h01);
            idle();
        end
        $display("test chip_erase done");
        prot <= 1'b1;
        cmd(`FCESR_OP_WREN, 32'h0, 3'd0);
        cmd(`FCESR_OP_ERASE_A, 32'h0, 3'd0);
        chk("prot_busy", busy, 32'h0);
        chk("prot_latch", wen, 32'h0);
        prot <= 1'b0;
        $display("test protected done");
        cmd(`FCESR_OP_WREN, 32'h0, 3'd0);
        cmd(`FCESR_OP_BLK4, 32'h0010_0000, 3'd3);
        cmd(`FCESR_OP_SUSPEND, 32'h0, 3'd0);
        chk("esus_set", esus, 32'h1);
        chk("esus_ready", busy, 32'h0);
        last_byte(`FCESR_OP_RDSTAT, 32'h0, 3'd1);
        chk("susp_stat", rd[15:8], 32'h04);
        cmd(`FCESR_OP_WREN, 32'h0, 3'd0);
        cmd(`FCESR_OP_WRSTAT, 32'h0, 3'd1);
        chk("wrstat_ign", wen, 32'h1);
        cmd(`FCESR_OP_PROG, 32'h0010_1033, 3'd4);
        chk("prog_abort", wen, 32'h0);
        last_byte(`FCESR_OP_READ, 32'h0010_0000, 3'd4);
        chk("read_undef", rd[15:8], 32'h5a);
        last_byte(`FCESR_OP_READ, 32'h3000_0000, 3'd4);
        chk("read_clean", rd[15:8], 32'hff);
        cmd(`FCESR_OP_WREN, 32'h0, 3'd0);
        cmd(`FCESR_OP_PROG, 32'h3000_0033, 3'd4);
        chk("prog_in_sus", busy, 32'h1);
        cmd(`FCESR_OP_SUSPEND, 32'h0, 3'd0);
        chk("prog_nosus", psus, 32'h0);
        cmd(`FCESR_OP_RESUME, 32'h0, 3'd0);
        chk("resume_busy_ign", esus, 32'h1);
        idle();
        cmd(`FCESR_OP_RESUME, 32'h0, 3'd0);
        chk("resume_flag", esus, 32'h0);
        chk("resume_busy", busy, 32'h1);
        cmd(`FCESR_OP_SUSPEND, 32'h0, 3'd0);
        chk("startup_nosus", esus, 32'h0);
        idle();
        $display("test erase_suspend done");
        cmd(`FCESR_OP_WREN, 32'h0, 3'd0);
        cmd(`FCESR_OP_PROG, 32'h2000_0011, 3'd4);
        cmd(`FCESR_OP_SUSPEND, 32'h0, 3'd0);
        chk("psus_set", psus, 32'h1);
        cmd(`FCESR_OP_WREN, 32'h0, 3'd0);
        cmd(`FCESR_OP_BLK64, 32'h20ff_0000, 3'd3);
        chk("erase_abort", wen, 32'h0);
        cmd(`FCESR_OP_RESUME, 32'h0, 3'd0);
        chk("psus_clear", psus, 32'h0);
        idle();
        $display("test program_suspend done");
        end_sim();
    end
endmodule
